// >>> ccs_device_end.sv
// monitor part end: start forwarding, conversion sequencing, spi registers
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ccs_device_end
  import ccs_pkg::*;
#(
  parameter int HOP_CYC_P  = HOP_CYC,
  parameter int CONV_CYC_P = CONV_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  ccs_link_if.dev         link,
  input  wire logic [11:0] adc_data,
  output logic      [3:0]  adc_channel,
  output logic             adc_hold,
  output logic             conv_busy,
  output logic             conv_done,
  output logic             termination_enable,
  output logic      [1:0]  alert_exclude
);
  // -------------------------------------------------------------
  // pin synchronisation
  // -------------------------------------------------------------
  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  ccs_pin_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pins    ({link.conversion_start_pin_n, link.cs_n, link.sclk, link.mosi}),
    .rst_val (4'hC),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );
  wire conversion_start_pin_fall = pin_fall[3];
  wire cs_low     = ~pin_lvl[2];
  wire cs_fall    = pin_fall[2];
  wire cs_rise    = pin_rise[2];
  wire sclk_rise  = pin_rise[1] & cs_low;
  wire sclk_fall  = pin_fall[1] & cs_low;
  wire mosi_lvl   = pin_lvl[0];
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [15:0] ctrl_r;
  logic [15:0] rx_r;
  logic [15:0] tx_r;
  logic [4:0]  bits_r;
  logic [3:0]  rd_ptr_r;
  logic [15:0] hop_r;
  logic        up_n_r;
  logic [1:0]  sel_run_r;
  logic [1:0]  avg_run_r;
  logic [1:0]  acq_run_r;
  logic [11:0] res_mem [NUM_RES];
  ccs_dev_st_e st_r, st_nxt;
  logic [3:0]  step_r, step_nxt;
  logic [2:0]  rep_r, rep_nxt;
  logic [14:0] acc_r, acc_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic        hold_nxt;
  logic        done_nxt;
  logic        store;
  // -------------------------------------------------------------
  // decode of frames and start requests
  // -------------------------------------------------------------
  wire        frame_ok = cs_rise & (bits_r == 5'h10);
  wire        wr_ctrl  = frame_ok & ~rx_r[F_KEEP];
  wire        rd_step  = frame_ok & rx_r[F_KEEP];
  wire        cs_conv  = wr_ctrl & rx_r[F_CONV];
  wire [15:0] cfg_w    = wr_ctrl ? rx_r : ctrl_r;
  wire        start_go = (conversion_start_pin_fall | cs_conv) & (st_r == DS_IDLE);
  // self-test may stay local; everything else is passed up
  wire        fwd      = start_go &
                         ~((cfg_w[F_CHSEL+:2] == SEL_TEST) & cfg_w[F_LOCAL]);
  wire [3:0]  n_conv   = ccs_count(sel_run_r);
  wire [3:0]  cur_ch   = ccs_chan(step_r, sel_run_r);
  wire [2:0]  rep_last = 3'((4'h1 << avg_run_r) - 4'h1);
  wire [15:0] acq_cyc  = 16'((int'(acq_run_r) + 1) * ACQ_STEP_CYC);
  wire [15:0] conv_cyc = 16'(CONV_CYC_P);
  wire [3:0]  rb_cnt   = ccs_count(ctrl_r[F_RDBK+:2]);
  wire [3:0]  rb_ch    = ccs_chan(rd_ptr_r, ctrl_r[F_RDBK+:2]);
  wire [15:0] rb_word  = {rb_ch, res_mem[rb_ch]};
  wire [3:0]  rd_inc   = rd_ptr_r + 4'h1;
  wire [11:0] avg_res  = 12'(acc_r >> avg_run_r);
  wire [15:0] hop_load = 16'(HOP_CYC_P + PULSE_CYC);
  wire        up_act   = (hop_r != 16'h0000) & (hop_r <= 16'(PULSE_CYC));
  // -------------------------------------------------------------
  // conversion sequencer
  // -------------------------------------------------------------
  // first conversion holds at once; later ones acquire first
  always_comb
  begin
    st_nxt   = st_r;
    step_nxt = step_r;
    rep_nxt  = rep_r;
    acc_nxt  = acc_r;
    tmr_nxt  = tmr_r;
    hold_nxt = 1'b0;
    done_nxt = 1'b0;
    store    = 1'b0;
    unique case (st_r)
      DS_IDLE:
      begin
        if (start_go)
        begin
          st_nxt   = DS_CONV;
          step_nxt = 4'h0;
          rep_nxt  = 3'h0;
          acc_nxt  = 15'h0000;
          tmr_nxt  = conv_cyc - 16'h0001;
          hold_nxt = 1'b1;
        end
      end
      DS_ACQ:
      begin
        if (tmr_r == 16'h0000)
        begin
          st_nxt   = DS_CONV;
          tmr_nxt  = conv_cyc - 16'h0001;
          hold_nxt = 1'b1;
        end
        else
          tmr_nxt = tmr_r - 16'h0001;
      end
      DS_CONV:
      begin
        if (tmr_r == 16'h0000)
        begin
          acc_nxt = acc_r + {3'h0, adc_data};
          if (rep_r == rep_last)
            st_nxt = DS_STORE;
          else
          begin
            rep_nxt = rep_r + 3'h1;
            st_nxt  = DS_ACQ;
            tmr_nxt = acq_cyc - 16'h0001;
          end
        end
        else
          tmr_nxt = tmr_r - 16'h0001;
      end
      DS_STORE:
      begin
        store   = 1'b1;
        acc_nxt = 15'h0000;
        rep_nxt = 3'h0;
        if (step_r == n_conv - 4'h1)
        begin
          st_nxt   = DS_IDLE;
          done_nxt = 1'b1;
        end
        else
        begin
          step_nxt = step_r + 4'h1;
          st_nxt   = DS_ACQ;
          tmr_nxt  = acq_cyc - 16'h0001;
        end
      end
    endcase
  end
  // sequencer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r      <= DS_IDLE;
      step_r    <= 4'h0;
      rep_r     <= 3'h0;
      acc_r     <= 15'h0000;
      tmr_r     <= 16'h0000;
      adc_hold  <= 1'b0;
      conv_done <= 1'b0;
    end
    else if (ce)
    begin
      st_r      <= st_nxt;
      step_r    <= step_nxt;
      rep_r     <= rep_nxt;
      acc_r     <= acc_nxt;
      tmr_r     <= tmr_nxt;
      adc_hold  <= hold_nxt;
      conv_done <= done_nxt;
    end
  end
  // run settings are latched so a write mid-sequence cannot tear it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_run_r <= SEL_ALL;
      avg_run_r <= 2'h0;
      acq_run_r <= 2'h0;
    end
    else if (ce && start_go)
    begin
      sel_run_r <= cfg_w[F_CHSEL+:2];
      avg_run_r <= cfg_w[F_AVG+:2];
      acq_run_r <= cfg_w[F_ACQ+:2];
    end
  end
  // result slots, one per channel plus the bandgap slot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_RES; i++)
        res_mem[i] <= 12'h000;
    end
    else if (ce && store)
      res_mem[cur_ch] <= avg_res;
  end
  // -------------------------------------------------------------
  // start forwarding up the chain
  // -------------------------------------------------------------
  // fixed hop per part, so skew at part n is n hops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hop_r  <= 16'h0000;
      up_n_r <= 1'b1;
    end
    else if (ce)
    begin
      if (fwd)
        hop_r <= hop_load;
      else if (hop_r != 16'h0000)
        hop_r <= hop_r - 16'h0001;
      up_n_r <= ~up_act;
    end
  end
  // -------------------------------------------------------------
  // serial control and readback
  // -------------------------------------------------------------
  // reset control word gives one conversion per channel
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r   <= CTRL_RST;
      rx_r     <= 16'h0000;
      bits_r   <= 5'h00;
      rd_ptr_r <= 4'h0;
    end
    else if (ce)
    begin
      if (cs_fall)
        bits_r <= 5'h00;
      else if (sclk_rise && bits_r != 5'h1F) // saturate so overlong frames are refused
      begin
        rx_r   <= {rx_r[14:0], mosi_lvl};
        bits_r <= bits_r + 5'h01;
      end
      if (wr_ctrl)
      begin
        ctrl_r   <= rx_r;
        rd_ptr_r <= 4'h0;
      end
      else if (rd_step)
        rd_ptr_r <= (rd_inc == rb_cnt) ? 4'h0 : rd_inc;
    end
  end
  // first bit is ready at cs fall; host samples on sclk rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_r <= 16'h0000;
    else if (ce)
    begin
      if (cs_fall)
        tx_r <= rb_word;
      else if (sclk_fall)
        tx_r <= {tx_r[14:0], 1'b0};
    end
  end
  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign link.miso          = tx_r[15];
  assign link.chain_up_n    = up_n_r;
  assign adc_channel        = cur_ch;
  assign conv_busy          = (st_r != DS_IDLE);
  assign termination_enable = ctrl_r[F_TERM];
  assign alert_exclude      = ctrl_r[F_XVT+:2];
endmodule // ccs_device_end
`default_nettype wire

// >>> ccs_host_end.sv
// host controller end: apb registers, spi frames and start pulses
`timescale 1ns/1ps
`default_nettype none
module ccs_host_end
  import ccs_pkg::*;
#(
  parameter int SETTLE_CYC_P = SETTLE_CYC,
  parameter int SCLK_HALF_P  = SCLK_HALF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  ccs_link_if.host         link
);
  logic        miso_lvl;
  ccs_pin_sync #(.W(1)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pins    (link.miso),
    .rst_val (1'b0),
    .level   (miso_lvl),
    .rise    (),
    .fall    ()
  );
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  ccs_host_st_e st_r;
  logic [15:0] word_r, last_r, tx_r, rxs_r, rsp_r, snd_r;
  logic [3:0]  pol_r;
  logic        pend_f_r, pend_p_r, rsp_new_r, chg_r;
  logic [19:0] settle_r;
  logic [7:0]  ph_r;
  logic [4:0]  bits_r;
  logic        sclk_r, cs_n_r, conversion_start_pin_n_r;
  logic [15:0] sane;
  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire hit     = (paddr == REG_WORD) | (paddr == REG_CMD) | (paddr == REG_STAT) |
                 (paddr == REG_RSP) | (paddr == REG_POL);
  wire busy    = (st_r != HS_IDLE) | pend_f_r | pend_p_r;
  wire settling = (settle_r != 20'h00000);
  wire cmd_wr  = wr & (paddr == REG_CMD);
  wire rsp_rd  = acc & ~pwrite & (paddr == REG_RSP);
  wire [31:0] rd_mux = (paddr == REG_WORD) ? {16'h0000, word_r} :
                       (paddr == REG_STAT) ? {29'h0, rsp_new_r, settling, busy} :
                       (paddr == REG_RSP)  ? {16'h0000, rsp_r} :
                       (paddr == REG_POL)  ? {28'h0, pol_r} : 32'h0;
  // policy overrides applied to every word sent
  always_comb
  begin
    sane = word_r;
    if (pol_r[0])
    begin
      sane[F_TERM]   = 1'b1;
      sane[F_ACQ+:2] = 2'h3;
    end
    if (pol_r[1])
      sane[15:12] = 4'h5;
    sane[F_XVT+:2] = sane[F_XVT+:2] | pol_r[3:2];
  end
  wire cfg_diff = (sane[F_AVG+:2] != last_r[F_AVG+:2]) |
                  (sane[F_ACQ+:2] != last_r[F_ACQ+:2]);
  wire split    = sane[F_CONV] & ~sane[F_KEEP] & cfg_diff;
  wire [15:0] send_w = split ? (sane & ~(16'h0001 << F_CONV)) : sane;
  wire go_p     = pend_p_r & ~settling;
  wire go_f     = pend_f_r & ~go_p & ~(send_w[F_CONV] & settling);
  wire tick     = (ph_r == 8'(SCLK_HALF_P - 1));
  wire f_end    = (st_r == HS_FRAME) & tick & ~sclk_r & (bits_r == 5'h10);
  // -------------------------------------------------------------
  // registers and apb answer
  // -------------------------------------------------------------
  // new requests win over the clear of a pending flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_r    <= CTRL_RST;
      pol_r     <= 4'h0;
      pend_f_r  <= 1'b0;
      pend_p_r  <= 1'b0;
      rsp_new_r <= 1'b0;
      prdata    <= 32'h0;
    end
    else if (ce)
    begin
      if (wr && paddr == REG_WORD)
        word_r <= pwdata[15:0];
      if (wr && paddr == REG_POL)
        pol_r <= pwdata[3:0];
      pend_f_r  <= (cmd_wr & pwdata[0]) | (pend_f_r & ~(st_r == HS_IDLE & go_f & ~split));
      pend_p_r  <= (cmd_wr & pwdata[1]) | (pend_p_r & ~(st_r == HS_IDLE & go_p));
      rsp_new_r <= f_end | (rsp_new_r & ~rsp_rd);
      if (psel && !penable)
        prdata <= rd_mux;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  // -------------------------------------------------------------
  // link sequencer
  // -------------------------------------------------------------
  // mosi changes on sclk fall, miso is taken on sclk rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r      <= HS_IDLE;
      ph_r      <= 8'h00;
      bits_r    <= 5'h00;
      sclk_r    <= 1'b0;
      cs_n_r    <= 1'b1;
      conversion_start_pin_n_r <= 1'b1;
      tx_r      <= 16'h0000;
      snd_r     <= 16'h0000;
      rxs_r     <= 16'h0000;
      rsp_r     <= 16'h0000;
      last_r    <= CTRL_RST;
      chg_r     <= 1'b0;
      settle_r  <= 20'h00000;
    end
    else if (ce)
    begin
      ph_r <= (st_r == HS_IDLE || tick) ? 8'h00 : ph_r + 8'h01;
      if (f_end && !snd_r[F_KEEP] && chg_r)
        settle_r <= 20'(SETTLE_CYC_P);
      else if (settling)
        settle_r <= settle_r - 20'h00001;
      unique case (st_r)
        HS_IDLE:
        begin
          if (go_p)
          begin
            st_r      <= HS_PULSE;
            conversion_start_pin_n_r <= 1'b0;
          end
          else if (go_f)
          begin
            st_r   <= HS_FRAME;
            cs_n_r <= 1'b0;
            bits_r <= 5'h00;
            tx_r   <= send_w;
            snd_r  <= send_w;
            chg_r  <= cfg_diff;
          end
        end
        HS_FRAME:
        begin
          if (f_end)
          begin
            st_r   <= HS_GAP;
            cs_n_r <= 1'b1;
            rsp_r  <= rxs_r;
            if (!snd_r[F_KEEP])
              last_r <= snd_r;
          end
          else if (tick && !sclk_r)
          begin
            sclk_r <= 1'b1;
            rxs_r  <= {rxs_r[14:0], miso_lvl};
          end
          else if (tick)
          begin
            sclk_r <= 1'b0;
            bits_r <= bits_r + 5'h01;
            tx_r   <= {tx_r[14:0], 1'b0};
          end
        end
        HS_GAP:
        begin
          if (tick)
            st_r <= HS_IDLE;
        end
        HS_PULSE:
        begin
          if (ph_r == 8'(PULSE_CYC - 1))
          begin
            conversion_start_pin_n_r <= 1'b1;
            st_r      <= HS_GAP;
          end
        end
      endcase
    end
  end
  assign link.conversion_start_pin_n = conversion_start_pin_n_r;
  assign link.cs_n                   = cs_n_r;
  assign link.sclk                   = sclk_r;
  assign link.mosi                   = tx_r[15];
endmodule // ccs_host_end
`default_nettype wire

// >>> ccs_link_if.sv
// link wires between the host controller and one monitor part
`timescale 1ns/1ps
`default_nettype none
interface ccs_link_if;
  logic conversion_start_pin_n;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic chain_up_n;
  modport host (output conversion_start_pin_n, output cs_n, output sclk,
                output mosi, input miso);
  modport dev  (input conversion_start_pin_n, input cs_n, input sclk,
                input mosi, output miso, output chain_up_n);
endinterface
`default_nettype wire

// >>> ccs_link_monitor.sv
// protocol checker watching the link between host and monitor part
`timescale 1ns/1ps
`default_nettype none
module ccs_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conversion_start_pin_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic chain_up_n
);
  // ----
  // helper: sclk rises per frame, cleared while deselected
  // ----
  logic       sclk_r;
  logic [4:0] nbits_r;
  wire logic  st_n = conversion_start_pin_n;
  wire logic [4:0] nbits_nxt = cs_n ? 5'h00 : nbits_r + {4'h0, sclk & ~sclk_r};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) sclk_r <= 1'b0;
    else sclk_r <= sclk;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) nbits_r <= 5'h00;
    else nbits_r <= nbits_nxt;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // properties
  // ----
  property p_start_len; $fell(st_n) |-> ##1 (!st_n)[*3] ##1 st_n; endproperty
  property p_up_len; $fell(chain_up_n) |-> ##1 (!chain_up_n)[*3] ##1 chain_up_n; endproperty
  property p_hop; $fell(st_n) |-> ##[11:20] $fell(chain_up_n); endproperty
  property p_idle; cs_n |-> !sclk; endproperty
  property p_half; $rose(sclk) |-> ##1 sclk[*7] ##1 !sclk; endproperty
  property p_mosi; !cs_n && sclk |-> $stable(mosi); endproperty
  property p_miso; !cs_n && sclk |-> $stable(miso); endproperty
  property p_bits; $rose(cs_n) |-> nbits_r == 5'h10; endproperty
  a_start_len: assert property (p_start_len) else $error("start pulse length");
  a_up_len: assert property (p_up_len) else $error("chain pulse length");
  a_hop: assert property (p_hop) else $error("hop delay");
  a_idle: assert property (p_idle) else $error("sclk not idle");
  a_half: assert property (p_half) else $error("sclk half period");
  a_mosi: assert property (p_mosi) else $error("mosi moved");
  a_miso: assert property (p_miso) else $error("miso moved");
  a_bits: assert property (p_bits) else $error("frame length");
  c_pulse: cover property ($fell(st_n));
  c_frame: cover property ($rose(cs_n));
  c_chain: cover property ($fell(chain_up_n));
endmodule // ccs_link_monitor
`default_nettype wire

// >>> ccs_pin_sync.sv
// two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ccs_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] pins,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] prev_r;
  logic [1:0]   fill_r;
  // -------------------------------------------------------------
  // sync chain; meta_r feeds only level
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      level  <= '0;
      prev_r <= '0;
      fill_r <= 2'h0;
    end
    else if (ce)
    begin
      meta_r <= pins;
      level  <= meta_r;
      prev_r <= level;
      if (fill_r != 2'h3)
        fill_r <= fill_r + 2'h1;
    end
  end
  // edges are taken from the settled stage only; idle-high pins show a
  // false rise while the chain refills after reset, so mask it until full
  assign rise = level & ~prev_r & ~(rst_val & {W{fill_r != 2'h3}});
  assign fall = ~level & prev_r;
endmodule // ccs_pin_sync
`default_nettype wire

// >>> ccs_pkg.sv
// shared constants, types and helpers for the chain conversion sequencer
`default_nettype none
package ccs_pkg;
  // -------------------------------------------------------------
  // clock and timing
  // -------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int ACQ_STEP_NS  = 400;
  localparam int ACQ_STEP_CYC = (ACQ_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_TIME_NS = 600;
  localparam int CONV_CYC     = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int HOP_NS       = 100;
  localparam int HOP_CYC      = (HOP_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_US    = 90;
  localparam int SETTLE_CYC   = SETTLE_US * CLK_MHZ;
  localparam int PULSE_CYC    = 4;
  localparam int SCLK_HALF    = 8;
  localparam int MAX_PARTS    = 20;
  // -------------------------------------------------------------
  // control word layout
  // -------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int F_CHSEL = 14;
  localparam int F_RDBK  = 12;
  localparam int F_CONV  = 11;
  localparam int F_AVG   = 9;
  localparam int F_KEEP  = 7;
  localparam int F_ACQ   = 5;
  localparam int F_LOCAL = 4;
  localparam int F_TERM  = 3;
  localparam int F_XVT   = 0;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0]  SEL_ALL  = 2'h0;
  localparam logic [1:0]  SEL_ODD  = 2'h1;
  localparam logic [1:0]  SEL_VOLT = 2'h2;
  localparam logic [1:0]  SEL_TEST = 2'h3;
  localparam int          NUM_RES  = 13;
  localparam logic [3:0]  BANDGAP_IDX = 4'hC;
  localparam logic [3:0]  NUM_VOLT    = 4'h6;
  // -------------------------------------------------------------
  // host register map (byte offsets)
  // -------------------------------------------------------------
  localparam logic [7:0] REG_WORD = 8'h00;
  localparam logic [7:0] REG_CMD  = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RSP  = 8'h0C;
  localparam logic [7:0] REG_POL  = 8'h10;
  typedef enum logic [1:0] {DS_IDLE = 2'b00, DS_ACQ = 2'b01, DS_CONV = 2'b10,
                            DS_STORE = 2'b11} ccs_dev_st_e;
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_FRAME = 2'b01, HS_GAP = 2'b10,
                            HS_PULSE = 2'b11} ccs_host_st_e;
  // conversions per start for a channel selection
  function automatic logic [3:0] ccs_count(input logic [1:0] sel);
    unique case (sel)
      SEL_ALL:  return 4'hC;
      SEL_ODD:  return 4'h9;
      SEL_VOLT: return 4'h6;
      SEL_TEST: return 4'h1;
    endcase
  endfunction
  // result slot of sequence step; voltages first, then selected temps
  function automatic logic [3:0] ccs_chan(input logic [3:0] step, input logic [1:0] sel);
    if (sel == SEL_TEST) return BANDGAP_IDX;
    if (step < NUM_VOLT) return step;
    if (sel == SEL_ODD) return NUM_VOLT + ((step - NUM_VOLT) << 1);
    return step;
  endfunction
endpackage
`default_nettype wire

// >>> testbench.sv
// self-checking bench: host end and part end joined over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccs_pkg::*;
  typedef struct { logic [15:0] w; logic [11:0] v; } ccs_row_s;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, err, hold, done, term;
  logic [1:0]  aex, sel, avg;
  logic [3:0]  chan;
  logic [11:0] adc = 12'h000;
  int          num_errors = 0, total_checks = 0, n_hold = 0, n_done = 0, base = 0;
  int          n_up = 0, n_frm = 0, up0 = 0, f0 = 0;
  logic [3:0]  prev_cfg = 4'h0;
  logic        cs_q = 1'b1;
  // start words: selection, readback, cs start, averaging, acquisition, local test
  ccs_row_s rows [6] = '{'{16'h0800, 12'h123}, '{16'h5A00, 12'h456}, '{16'hAE60, 12'h789},
                         '{16'hF800, 12'hABC}, '{16'h0C20, 12'hDEF}, '{16'hF810, 12'h321}};
  ccs_link_if lk ();
  ccs_host_end #(.SETTLE_CYC_P(50), .SCLK_HALF_P(8)) u_ccs_host_end (.pclk(pclk),
    .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(lk.host));
  ccs_device_end u_ccs_device_end (.pclk(pclk), .presetn(presetn), .ce(1'b1), .link(lk.dev),
    .adc_data(adc), .adc_channel(chan), .adc_hold(hold), .conv_busy(), .conv_done(done),
    .termination_enable(term), .alert_exclude(aex));
  ccs_link_monitor u_mon (.pclk(pclk), .presetn(presetn), .cs_n(lk.cs_n), .sclk(lk.sclk),
    .conversion_start_pin_n(lk.conversion_start_pin_n), .mosi(lk.mosi), .miso(lk.miso),
    .chain_up_n(lk.chain_up_n));
  always #5 pclk = ~pclk;
  // ----
  // helpers
  // ----
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // apb master: hold the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // send one word, then poll until busy and settling are both clear
  task automatic send(input logic [15:0] w);
    apb(1'b1, REG_WORD, {16'h0, w});
    apb(1'b1, REG_CMD, 32'h1);
    apb(1'b0, REG_STAT, 32'h0);
    while (q[1:0] !== 2'b00) apb(1'b0, REG_STAT, 32'h0);
  endtask
  function automatic logic [15:0] exp_cnt(input logic [1:0] s);
    return s == 2'h0 ? 16'hC : s == 2'h1 ? 16'h9 : s == 2'h2 ? 16'h6 : 16'h1;
  endfunction
  function automatic logic [3:0] slot_of(input int s);
    return 4'(sel == 2'h3 ? 12 : s < 6 ? s : sel == 2'h1 ? 6 + 2 * (s - 6) : s);
  endfunction
  // each conversion must sit on the slot that the sequence order expects
  always @(posedge pclk)
  begin
    if (hold === 1'b1)
    begin
      chk({12'h0, chan}, {12'h0, slot_of((n_hold - base) >> avg)});
      n_hold++;
    end
    if (done === 1'b1) n_done++;
    if (lk.chain_up_n === 1'b0) n_up++;
    if (lk.cs_n === 1'b1 && cs_q === 1'b0) n_frm++;
    cs_q <= lk.cs_n;
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    fork
      begin
        #1ms;
        num_errors++;
        conclude();
      end
    join_none
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    foreach (rows[i])
    begin
      sel = rows[i].w[15:14];
      avg = rows[i].w[10:9];
      adc <= rows[i].v;
      base = n_hold;
      up0 = n_up;
      f0 = n_frm;
      send(rows[i].w);
      chk(16'(n_frm - f0), 16'(1 + ({rows[i].w[10:9], rows[i].w[6:5]} != prev_cfg)));
      prev_cfg = {rows[i].w[10:9], rows[i].w[6:5]};
      while (n_done < i + 1) @(posedge pclk);
      chk(16'(n_hold - base), exp_cnt(sel) << avg);
      chk(16'(n_up - up0), (sel == 2'h3 && rows[i].w[4]) ? 16'h0 : 16'(PULSE_CYC));
      send(rows[i].w & 16'hF7FF | 16'h0080);
      apb(1'b0, REG_RSP, 32'h0);
      chk(q[15:0], {sel == 2'h3 ? 4'hC : 4'h0, rows[i].v});
    end
    // policy register forces termination, three temps and alert exclusion
    apb(1'b1, REG_POL, 32'hF);
    sel = 2'h1;
    avg = 2'h0;
    base = n_hold;
    send(16'h0800);
    while (n_done < 7) @(posedge pclk);
    chk(16'(n_hold - base), 16'h9);
    repeat (8) @(posedge pclk);
    chk({15'h0, term}, 16'h1);
    chk({14'h0, aex}, 16'h3);
    // unmapped address is refused and reads zero
    apb(1'b0, 8'h14, 32'h0);
    chk({15'h0, err}, 16'h1);
    chk(q[15:0], 16'h0);
    // second reset after the policy run, then a pin pulse runs with default settings
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({15'h0, term}, 16'h0);
    sel = 2'h0;
    avg = 2'h0;
    base = n_hold;
    apb(1'b1, REG_CMD, 32'h2);
    while (n_done < 8) @(posedge pclk);
    chk(16'(n_hold - base), 16'hC);
    conclude();
  end
endmodule // testbench
`default_nettype wire
